/* dv/jcle_bus_model.sv */
// jcle_bus_model: stack-write slave, acks each push dly+1 cycles after req rises
// assumes one push at a time; ack is a one-cycle pulse
`timescale 1ns/10ps
module jcle_bus_model
  import jcle_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire jcle_push_t push,
  input wire logic [7:0] dly,
  output logic pushAck,
  output logic [31:0] lastAddr,
  output logic [31:0] lastData
);
  logic [7:0] cnt;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pushAck <= 1'b0;
      cnt <= 8'h00;
    end else if (pushAck) begin
      pushAck <= 1'b0;
    end else if (push.req) begin
      cnt <= cnt + 8'h01;
      if (cnt >= dly) begin
        pushAck <= 1'b1;
        cnt <= 8'h00;
        lastAddr <= push.addr;
        lastData <= push.data;
      end
    end
  end
endmodule

/* dv/jcle_exec_sva.sv */
// jcle_exec_sva: port-level checks of the jump/call/load/link unit
// assumes it is bound into jcle_exec
`timescale 1ns/10ps
module jcle_exec_sva
  import jcle_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire jcle_instr_t instr,
  input wire logic instrReady,
  input wire logic instrDone,
  input wire logic illegalInstr,
  input wire logic pcLoad,
  input wire logic [31:0] programCounter,
  input wire logic [31:0] stackPointer,
  input wire jcle_push_t push,
  input wire logic ccWriteEn
);
  logic take;
  logic [9:0] hi;
  logic [2:0] md;
  assign take = instr.valid && instrReady;
  assign hi = instr.opcode[15:6];
  assign md = instr.opcode[5:3];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_cc_never: assert property (ccWriteEn == 1'b0)
    else $error("flags written");
  a_jump_pc: assert property (take && hi == OPC_JUMP_HI && md == MODE_IND
    |=> pcLoad && programCounter == $past(instr.effAddr)) else $error("jump");
  a_bad_mode: assert property (take && hi == OPC_JUMP_HI && md == 3'h0
    |=> illegalInstr && !pcLoad) else $error("bad mode run");
  a_imm_reject: assert property (take && hi == OPC_CALL_HI
    && instr.opcode[5:0] == 6'h3C |=> illegalInstr && !push.req)
    else $error("immediate taken");
  a_call_push: assert property (take && hi == OPC_CALL_HI && md == MODE_DISP
    |=> push.req && push.data == $past(instr.nextPc)) else $error("call");
  a_push_dec: assert property ($rose(push.req) |-> stackPointer == push.addr
    && push.addr == $past(stackPointer) - PUSH_BYTES) else $error("push");
  a_link_push: assert property (take && instr.opcode[15:3] == OPC_LINK_HI
    |=> !push.req ##1 push.req) else $error("link push");
  a_load_ok: assert property (take && instr.opcode[15:12] == OPC_LOAD_TOP
    && instr.opcode[8:6] == LOAD_OPMODE && md == MODE_DISP
    |=> instrDone && !illegalInstr && !pcLoad) else $error("load");
endmodule
bind jcle_exec jcle_exec_sva u_sva (.clk(clk), .rst_b(rst_b), .instr(instr),
  .instrReady(instrReady), .instrDone(instrDone),
  .illegalInstr(illegalInstr), .pcLoad(pcLoad),
  .programCounter(programCounter), .stackPointer(stackPointer),
  .push(push), .ccWriteEn(ccWriteEn));

/* dv/test_jcle_exec.sv */
// test_jcle_exec: directed scenarios for the jump/call/load/link unit
// assumes jcle_bus_model answers stack pushes
`timescale 1ns/10ps
module test_jcle_exec
  import jcle_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  jcle_instr_t instr = '0;
  logic [2:0] srcRegIdx = 3'h0;
  logic pushAck, instrReady, instrDone, illegalInstr, pcLoad, ccWriteEn;
  logic [31:0] programCounter, stackPointer, addressRegister;
  logic [31:0] lastAddr, lastData, expSp = '0, expPc = '0;
  jcle_push_t push;
  logic [7:0] dly = 8'h00;
  int err_count = 0;
  int checks = 0;
  localparam logic [5:0] GOOD [7] = '{6'h10, 6'h2B, 6'h35, 6'h38, 6'h39,
    6'h3A, 6'h3B};
  // direct, areg, postinc, predec, immediate, reserved sub-form
  localparam logic [5:0] BAD [6] = '{6'h00, 6'h0A, 6'h1A, 6'h21, 6'h3C, 6'h3F};
  jcle_exec u_dut (.clk(clk), .rst_b(rst_b), .instr(instr),
    .pushAck(pushAck), .srcRegIdx(srcRegIdx), .instrReady(instrReady),
    .instrDone(instrDone), .illegalInstr(illegalInstr), .pcLoad(pcLoad),
    .programCounter(programCounter), .stackPointer(stackPointer),
    .push(push), .ccWriteEn(ccWriteEn), .addressRegister(addressRegister));
  jcle_bus_model u_bus (.clk(clk), .rst_b(rst_b), .push(push), .dly(dly),
    .pushAck(pushAck), .lastAddr(lastAddr), .lastData(lastData));
  always #5 clk = ~clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // called at a falling edge; returns at the falling edge inside done
  task automatic issue(input logic [15:0] op, input logic [31:0] ea,
    input logic [15:0] ext, input logic [31:0] np);
    int n;
    n = 0;
    instr = '{1'b1, op, ext, ea, np};
    while (instrReady !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    instr.valid = 1'b0;
    while (instrDone !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk({31'h0, n < 50}, 32'h1);
  endtask
  task automatic t_jump;
    for (int i = 0; i < 7; i++) begin
      expPc = 32'h0000_2000 + 32'(i * 4);
      issue({OPC_JUMP_HI, GOOD[i]}, expPc, 16'h0, 32'h0);
      chk({31'h0, illegalInstr}, 32'h0);
      chk(programCounter, expPc);
    end
  endtask
  task automatic t_bad;
    logic [15:0] op;
    for (int i = 0; i < 6; i++) begin
      for (int j = 0; j < 3; j++) begin
        op = j == 0 ? {OPC_JUMP_HI, BAD[i]} : j == 1 ? {OPC_CALL_HI, BAD[i]}
          : {OPC_LOAD_TOP, 3'h1, LOAD_OPMODE, BAD[i]};
        issue(op, 32'h0000_9000, 16'h0, 32'h0);
        chk({31'h0, illegalInstr}, 32'h1);
        chk(programCounter, expPc);
      end
    end
  endtask
  task automatic t_call(input logic [5:0] code, input logic [7:0] d);
    dly = d;
    expSp = expSp - PUSH_BYTES;
    expPc = expPc + 32'h100;
    issue({OPC_CALL_HI, code}, expPc, 16'h0, 32'h4A4A + expSp);
    chk(lastAddr, expSp);
    chk(lastData, 32'h4A4A + expSp);
    chk(programCounter, expPc);
    chk(stackPointer, expSp);
  endtask
  // load fills register 3, link then pushes it and rebuilds the frame
  task automatic t_link;
    issue({OPC_LOAD_TOP, 3'h3, LOAD_OPMODE, 6'h2D}, 32'h8000_00F0, 16'h0, '0);
    chk({31'h0, illegalInstr}, 32'h0);
    dly = 8'h02;
    issue({OPC_LINK_HI, 3'h3}, 32'h0, 16'hFFF0, 32'h0);
    expSp = expSp - PUSH_BYTES;
    chk(lastData, 32'h8000_00F0);
    chk(lastAddr, expSp);
    // a non-link opcode hands the read port to srcRegIdx
    instr.opcode = {OPC_JUMP_HI, 6'h10};
    srcRegIdx = 3'h3;
    repeat (2) @(negedge clk);
    chk(addressRegister, expSp);
    chk(stackPointer, expSp - 32'h10);
  endtask
  task automatic end_sim;
    if (err_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    t_jump;
    t_bad;
    t_call(6'h2A, 8'h03);
    t_call(6'h39, 8'h00);
    t_link;
    end_sim;
  end
  initial begin
    #100000;
    err_count++;
    end_sim;
  end
endmodule

/* hw/jcle_areg_file.sv */
// jcle_areg_file: eight 32-bit address registers, one write port
// assumes a single clock; read data are registered
`timescale 1ns/10ps
module jcle_areg_file
  import jcle_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic writeEn,
  input wire logic [$clog2(DEPTH)-1:0] writeIdx,
  input wire logic [WIDTH-1:0] writeData,
  input wire logic [$clog2(DEPTH)-1:0] readIdx,
  output logic [WIDTH-1:0] readData
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] rd;
  } jcle_rf_state_t;

  jcle_rf_state_t state;
  jcle_rf_state_t next_state;

  always_comb begin
    next_state = state;
    // bypass: a load followed at once by link must push the new value
    if (writeEn && writeIdx == readIdx) begin
      next_state.rd = writeData;
    end else begin
      next_state.rd = state.mem[readIdx];
    end
    if (writeEn) begin
      next_state.mem[writeIdx] = writeData;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign readData = state.rd;
endmodule

/* hw/jcle_exec.sv */
// jcle_exec: decode and execute jump, call, load-address and frame-link
// assumes fetch presents opcode, extension word, computed effective address
// and following-instruction address together; stack pushes go out as one
// 32-bit write that the bus acknowledges.
`timescale 1ns/10ps
module jcle_exec
  import jcle_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire jcle_instr_t instr,
  input wire logic pushAck,
  input wire logic [2:0] srcRegIdx,
  output logic instrReady,
  output logic instrDone,
  output logic illegalInstr,
  output logic pcLoad,
  output logic [31:0] programCounter,
  output logic [31:0] stackPointer,
  output jcle_push_t push,
  output logic ccWriteEn,
  output logic [31:0] addressRegister
);
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_PUSH, ST_FIN} jcle_state_e_t;

  typedef struct packed {
    jcle_state_e_t fsm;
    logic isLink;
    logic [2:0] linkIdx;
    logic [31:0] target;
    logic [31:0] disp;
    logic [31:0] pc;
    logic [31:0] sp;
    logic rdy;
    logic done;
    logic illegal;
    logic pcLd;
    jcle_push_t push;
    logic wrEn;
    logic [2:0] wrIdx;
    logic [31:0] wrData;
  } jcle_state_t;

  jcle_state_t state;
  jcle_state_t next_state;
  logic [31:0] regRead;
  logic [2:0] readSel;
  jcle_ctrl_t ctrlOp;
  logic isLinkOp;
  logic modeOk;
  logic [2:0] eaMode;
  logic [2:0] eaReg;

  assign eaMode = instr.opcode[5:3];
  assign eaReg = instr.opcode[2:0];

  always_comb begin
    unique case (eaMode)
      MODE_IND, MODE_DISP, MODE_IDX: modeOk = 1'b1;
      MODE_EXT: modeOk = (eaReg >= SUB_ABS_SHORT) &&
                         (eaReg <= SUB_PC_IDX);
      default: modeOk = 1'b0;
    endcase
  end

  always_comb begin
    ctrlOp = OP_NONE;
    if (instr.opcode[15:6] == OPC_JUMP_HI) begin
      ctrlOp = OP_JUMP;
    end else if (instr.opcode[15:6] == OPC_CALL_HI) begin
      ctrlOp = OP_CALL;
    end else if (instr.opcode[15:12] == OPC_LOAD_TOP &&
                 instr.opcode[8:6] == LOAD_OPMODE) begin
      ctrlOp = OP_LOAD;
    end
    isLinkOp = (instr.opcode[15:3] == OPC_LINK_HI);
  end

  // link reads its register; the file answers one cycle later
  assign readSel = isLinkOp ? instr.opcode[2:0] : srcRegIdx;

  jcle_areg_file #(
    .WIDTH(32),
    .DEPTH(8)
  ) u_areg (
    .clk(clk),
    .rst_b(rst_b),
    .writeEn(state.wrEn),
    .writeIdx(state.wrIdx),
    .writeData(state.wrData),
    .readIdx(state.fsm == ST_IDLE ? readSel : state.linkIdx),
    .readData(regRead)
  );

  always_comb begin
    next_state = state;
    next_state.done = 1'b0;
    next_state.illegal = 1'b0;
    next_state.pcLd = 1'b0;
    next_state.wrEn = 1'b0;
    unique case (state.fsm)
      ST_IDLE: begin
        next_state.rdy = 1'b1;
        if (instr.valid && state.rdy) begin
          if (isLinkOp) begin
            next_state.isLink = 1'b1;
            next_state.linkIdx = instr.opcode[2:0];
            next_state.disp = {{16{instr.extWord[15]}},
                               instr.extWord};
            next_state.rdy = 1'b0;
            next_state.fsm = ST_READ;
          end else if (ctrlOp != OP_NONE && !modeOk) begin
            next_state.illegal = 1'b1;
            next_state.done = 1'b1;
          end else if (ctrlOp == OP_JUMP) begin
            next_state.pc = instr.effAddr;
            next_state.pcLd = 1'b1;
            next_state.done = 1'b1;
          end else if (ctrlOp == OP_LOAD) begin
            next_state.wrEn = 1'b1;
            next_state.wrIdx = instr.opcode[11:9];
            next_state.wrData = instr.effAddr;
            next_state.done = 1'b1;
          end else if (ctrlOp == OP_CALL) begin
            next_state.isLink = 1'b0;
            next_state.target = instr.effAddr;
            next_state.sp = state.sp - PUSH_BYTES;
            next_state.push.req = 1'b1;
            next_state.push.addr = state.sp - PUSH_BYTES;
            next_state.push.data = instr.nextPc;
            next_state.rdy = 1'b0;
            next_state.fsm = ST_PUSH;
          end else begin
            next_state.illegal = 1'b1;
            next_state.done = 1'b1;
          end
        end
      end
      ST_READ: begin
        // sp itself is not in the file; link through register 7 pushes file entry 7, not current sp
        next_state.sp = state.sp - PUSH_BYTES;
        next_state.push.req = 1'b1;
        next_state.push.addr = state.sp - PUSH_BYTES;
        next_state.push.data = regRead;
        next_state.fsm = ST_PUSH;
      end
      ST_PUSH: begin
        if (pushAck) begin
          next_state.push.req = 1'b0;
          next_state.fsm = ST_FIN;
        end
      end
      ST_FIN: begin
        if (state.isLink) begin
          next_state.wrEn = 1'b1;
          next_state.wrIdx = state.linkIdx;
          next_state.wrData = state.sp;
          next_state.sp = state.sp + state.disp;
        end else begin
          next_state.pc = state.target;
          next_state.pcLd = 1'b1;
        end
        next_state.done = 1'b1;
        next_state.fsm = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= '{fsm: ST_IDLE, pc: PC_RESET, sp: SP_RESET, default: '0};
    end else begin
      state <= next_state;
    end
  end

  assign instrReady = state.rdy;
  assign instrDone = state.done;
  assign illegalInstr = state.illegal;
  assign pcLoad = state.pcLd;
  assign programCounter = state.pc;
  assign stackPointer = state.sp;
  assign push = state.push;
  assign ccWriteEn = 1'b0;
  assign addressRegister = regRead;
endmodule

/* hw/jcle_pkg.sv */
// jcle_pkg: constants and carrier types for the jump/call/load/link unit
// assumes a 16-bit opcode stream and a 32-bit address space
package jcle_pkg;
  localparam logic [9:0] OPC_JUMP_HI = 10'h13B;
  localparam logic [9:0] OPC_CALL_HI = 10'h13A;
  localparam logic [12:0] OPC_LINK_HI = 13'h09CA;
  localparam logic [3:0] OPC_LOAD_TOP = 4'h4;
  localparam logic [2:0] LOAD_OPMODE = 3'h7;
  localparam logic [2:0] MODE_IND = 3'h2;
  localparam logic [2:0] MODE_DISP = 3'h5;
  localparam logic [2:0] MODE_IDX = 3'h6;
  localparam logic [2:0] MODE_EXT = 3'h7;
  localparam logic [2:0] SUB_ABS_SHORT = 3'h0;
  localparam logic [2:0] SUB_PC_IDX = 3'h3;
  localparam logic [31:0] PUSH_BYTES = 32'h0000_0004;
  localparam logic [31:0] PC_RESET = 32'h0000_0000;
  localparam logic [31:0] SP_RESET = 32'h0000_0000;
  localparam logic [2:0] SP_INDEX = 3'h7;

  typedef enum logic [1:0] {OP_NONE, OP_JUMP, OP_CALL, OP_LOAD} jcle_ctrl_t;

  typedef struct packed {
    logic valid;
    logic [15:0] opcode;
    logic [15:0] extWord;
    logic [31:0] effAddr;
    logic [31:0] nextPc;
  } jcle_instr_t;

  typedef struct packed {
    logic req;
    logic [31:0] addr;
    logic [31:0] data;
  } jcle_push_t;
endpackage
